//--- idg_engine.sv
// Datagram command engine: decode, serial and SPI paths, config access, replies
//
// Behaviour
// [RULE_01] Signature, opcode, transaction id head every datagram
// [RULE_02] Host sends serial data with opcode 0x0006
// [RULE_03] Serial-output payload goes out serial port
// [RULE_04] Zero length accepted, no serial bytes
// [RULE_05] SPI upload: 0x0007, timestamp, address, length, data
// [RULE_06] SPI port is always clock master
// [RULE_07] Auto event polls slave, uploads captured bytes
// [RULE_08] Opcode 0x0008 payload clocked out over SPI
// [RULE_09] Config read 0x0010 with length, bank, location
// [RULE_10] Read answered by 0x0011 echoing bank, location
// [RULE_11] Read reply length counts bank, location, value
// [RULE_12] Read reply value least significant byte first
// [RULE_13] Config write 0x0012, value low byte first
// [RULE_14] Write answered by 0x0013 with length, status
// [RULE_15] Write status 0 success, 1 failure
// [RULE_16] Config requests handled only while awake
// [RULE_17] Config requests from any of three paths
// [RULE_18] Serial string in sends 0x0005 upload
// [RULE_19] Unknown signature or opcode silently dropped
`default_nettype none
module idg_engine
	import idg_pkg::*;
(
	input wire logic I_CLK_SYS,
	input wire logic I_RESET_N,
	input wire logic [7:0] I_RX_DATA,
	input wire logic I_RX_VALID,
	input wire logic I_RX_LAST,
	input wire logic [1:0] I_RX_PATH,
	output logic O_RX_READY,
	output logic [7:0] O_TX_DATA,
	output logic O_TX_VALID,
	output logic O_TX_LAST,
	output logic [1:0] O_TX_PATH,
	input wire logic I_TX_READY,
	output logic [7:0] O_SER_DATA,
	output logic O_SER_VALID,
	input wire logic I_SER_READY,
	input wire logic [7:0] I_SRX_DATA,
	input wire logic I_SRX_VALID,
	input wire logic I_SRX_LAST,
	output logic O_SRX_READY,
	output logic O_SPI_SCLK,
	output logic O_SPI_MOSI,
	output logic O_SPI_CS_N,
	input wire logic I_SPI_MISO,
	input wire logic I_AUTO_EVT,
	input wire logic [31:0] I_POLL_CMD,
	input wire logic [47:0] I_MAC_ADDR,
	input wire logic I_AWAKE,
	output logic O_CFG_REQ,
	output logic O_CFG_WR,
	output logic [15:0] O_CFG_BANK,
	output logic [15:0] O_CFG_LOC,
	output logic [31:0] O_CFG_WDATA,
	input wire logic I_CFG_ACK,
	input wire logic [31:0] I_CFG_RDATA,
	input wire logic I_CFG_ERR
);
	idg_state_t st_q, st_d;
	logic [79:0] sh_q;
	logic [4:0] cnt_q;
	logic [15:0] op_q, tid_q, utid_q;
	logic [1:0] path_q;
	logic [8:0] pay_q, wcnt_q, dcnt_q;
	logic [191:0] hdr_q;
	logic [4:0] hcnt_q;
	logic [7:0] didx_q;
	logic last_q, auto_pend_q, req_q, wr_q;
	logic [31:0] addr_q, wd_q;
	logic [7:0] ser_q;
	logic ser_v_q;
	logic [63:0] ts_q;
	logic [9:0] tick_q;
	logic [2:0] pidx_q, div_q;
	logic [3:0] half_q;
	logic spi_busy_q, spi_done_q, sclk_q, miso_m_q, miso_s_q;
	logic [7:0] spi_sh_q, spi_rx_q;
	idg_buf_if buf_bus ();

	idg_buf_mem u_buf (.i_clk(I_CLK_SYS), .bus(buf_bus.mem));

	////////////////////////////////////////////////////////////////
	// Decode
	wire rx_fire = I_RX_VALID & O_RX_READY;
	wire tx_fire = O_TX_VALID & I_TX_READY;
	wire srx_fire = I_SRX_VALID & O_SRX_READY;
	wire tx_dat = hcnt_q == 5'h00;
	wire tx_end = tx_fire & O_TX_LAST;
	wire [79:0] hd_w = {sh_q[71:0], I_RX_DATA};
	wire sig_ok = hd_w[79:48] == SIG;
	wire [15:0] op_w = hd_w[47:32];
	wire [15:0] len_w = hd_w[15:0];
	wire [8:0] pay_w = (len_w > MAX_LEN) ? MAX_LEN[8:0] : len_w[8:0];
	wire is_cfg = (op_w == OP_CRD) | (op_w == OP_CWR);
	wire decide = (st_q == ST_RXH) & rx_fire & (cnt_q == HDR_LAST);
	wire [4:0] cfg_last = (op_q == OP_CWR) ? CWR_LAST : CRD_LAST; // RULE_09
	wire pay_go = (pay_w != 9'h000) & !I_RX_LAST; // RULE_04
	idg_state_t rest_w, after_w;
	assign rest_w = I_RX_LAST ? ST_IDLE : ST_DRAIN;
	assign after_w = last_q ? ST_IDLE : ST_DRAIN;
	wire auto_go = (st_q == ST_AUTO) & !spi_busy_q & !spi_done_q & (pidx_q != POLL_BYTES);
	wire spi_start = ((st_q == ST_SPIDL) & rx_fire) | auto_go;
	wire [7:0] spi_byte = (st_q == ST_AUTO) ? I_POLL_CMD[8 * (3 - pidx_q) +: 8] : I_RX_DATA;
	wire spi_tick = div_q == SPI_DIV_LAST;
	wire mem_we = srx_fire | ((st_q == ST_AUTO) & spi_done_q);
	wire [8:0] wcnt_d = wcnt_q + {8'h00, mem_we};
	wire to_tx = (st_d == ST_TX) & (st_q != ST_TX);

	assign O_RX_READY = (st_q == ST_RXH) | (st_q == ST_CFGF) | (st_q == ST_DRAIN)
		| ((st_q == ST_SERW) & (pay_q != 9'h000) & (!ser_v_q | I_SER_READY))
		| ((st_q == ST_SPIDL) & (pay_q != 9'h000) & !spi_busy_q);
	assign O_SRX_READY = (st_q == ST_SRX) & (wcnt_q <= MAX_LAST);
	assign O_TX_VALID = st_q == ST_TX;
	assign O_TX_DATA = tx_dat ? buf_bus.rdata : hdr_q[191:184];
	assign O_TX_LAST = tx_dat ? (dcnt_q == 9'h001) : ((hcnt_q == 5'h01) & (dcnt_q == 9'h000));
	assign O_TX_PATH = path_q;
	assign O_SER_DATA = ser_q;
	assign O_SER_VALID = ser_v_q;
	assign O_SPI_SCLK = sclk_q; // RULE_06
	assign O_SPI_MOSI = spi_sh_q[7];
	assign O_SPI_CS_N = !((st_q == ST_SPIDL) | (st_q == ST_AUTO));
	assign O_CFG_REQ = req_q;
	assign O_CFG_WR = wr_q;
	assign O_CFG_BANK = addr_q[31:16];
	assign O_CFG_LOC = addr_q[15:0];
	assign O_CFG_WDATA = wd_q;
	assign buf_bus.we = mem_we;
	assign buf_bus.waddr = wcnt_q[BUF_AW-1:0];
	assign buf_bus.wdata = (st_q == ST_SRX) ? I_SRX_DATA : spi_rx_q;
	assign buf_bus.raddr = (tx_dat & tx_fire) ? didx_q + 8'h01 : didx_q;

	////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE:
				if (I_RX_VALID) st_d = ST_RXH;
				else if (auto_pend_q) st_d = ST_AUTO;
				else if (I_SRX_VALID) st_d = ST_SRX;
			ST_RXH:
				if (decide)
				begin
					if (!sig_ok) st_d = rest_w; // RULE_19
					else if (op_w == OP_SERW && pay_go) st_d = ST_SERW;
					else if (op_w == OP_SPIW && pay_go) st_d = ST_SPIDL;
					else if (is_cfg && I_AWAKE && !I_RX_LAST) st_d = ST_CFGF; // RULE_16
					else st_d = rest_w;
				end
				else if (rx_fire && I_RX_LAST) st_d = ST_IDLE;
			ST_CFGF:
				if (rx_fire && cnt_q == cfg_last) st_d = ST_CFG;
				else if (rx_fire && I_RX_LAST) st_d = ST_IDLE;
			ST_CFG:
				if (I_CFG_ACK) st_d = ST_TX;
			ST_TX:
				if (tx_end) st_d = after_w;
			ST_DRAIN:
				if (rx_fire && I_RX_LAST) st_d = ST_IDLE;
			ST_SERW:
				if (rx_fire && (I_RX_LAST || pay_q == 9'h001)) st_d = rest_w;
			ST_SPIDL:
				if (pay_q == 9'h000 && !spi_busy_q) st_d = after_w;
			ST_AUTO:
				if (pidx_q == POLL_BYTES && !spi_busy_q && !spi_done_q) st_d = ST_TX;
			ST_SRX:
				if (srx_fire && (I_SRX_LAST || wcnt_q == MAX_LAST)) st_d = ST_TX;
			default:
				st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RESET_N)
		begin
			st_q <= ST_IDLE;
			cnt_q <= 5'h00;
			sh_q <= 80'h0;
			last_q <= 1'b1;
			auto_pend_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= (st_q == ST_IDLE) ? 5'h00 : cnt_q + {4'h0, rx_fire};
			if (rx_fire) sh_q <= hd_w;
			last_q <= (st_q == ST_IDLE) ? !I_RX_VALID : last_q | (rx_fire & I_RX_LAST);
			// A new event wins over the clear taken on entry
			auto_pend_q <= I_AUTO_EVT | (auto_pend_q & !(st_q == ST_IDLE && st_d == ST_AUTO)); // RULE_07
		end
	end

	////////////////////////////////////////////////////////////////
	// Inbound fields, config access, serial out
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RESET_N)
		begin
			op_q <= 16'h0000;
			tid_q <= 16'h0000;
			path_q <= 2'h0;
			pay_q <= 9'h000;
			addr_q <= 32'h0;
			wd_q <= 32'h0;
			wr_q <= 1'b0;
			req_q <= 1'b0;
			ser_q <= 8'h00;
			ser_v_q <= 1'b0;
		end
		else
		begin
			if (st_q == ST_IDLE) path_q <= 2'h0;
			if (decide)
			begin
				op_q <= op_w;
				tid_q <= hd_w[31:16];
				path_q <= I_RX_PATH; // RULE_17
				pay_q <= pay_w;
			end
			else if (rx_fire && (st_q == ST_SERW || st_q == ST_SPIDL))
				pay_q <= I_RX_LAST ? 9'h000 : pay_q - 9'h001;
			if (st_q == ST_CFGF && st_d == ST_CFG)
			begin
				addr_q <= (op_q == OP_CWR) ? hd_w[63:32] : hd_w[31:0];
				wd_q <= idg_swap32(hd_w[31:0]); // RULE_13
				wr_q <= op_q == OP_CWR;
			end
			req_q <= st_d == ST_CFG;
			if (st_q == ST_SERW && rx_fire) ser_q <= I_RX_DATA; // RULE_03
			ser_v_q <= (st_q == ST_SERW & rx_fire) | (ser_v_q & !I_SER_READY);
		end
	end

	////////////////////////////////////////////////////////////////
	// Reply and upload transmitter
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RESET_N)
		begin
			hdr_q <= 192'h0;
			hcnt_q <= 5'h00;
			dcnt_q <= 9'h000;
			didx_q <= 8'h00;
			wcnt_q <= 9'h000;
			utid_q <= 16'h0000;
		end
		else
		begin
			wcnt_q <= (st_q == ST_IDLE) ? 9'h000 : wcnt_d;
			if (to_tx && st_q == ST_CFG && !wr_q)
			begin
				hdr_q <= {SIG, OP_CRDR, tid_q, LEN_RDR, addr_q, idg_swap32(I_CFG_RDATA), 48'h0}; // RULE_10 RULE_11 RULE_12
				hcnt_q <= RDR_HDR;
				dcnt_q <= 9'h000;
			end
			else if (to_tx && st_q == ST_CFG)
			begin
				hdr_q <= {SIG, OP_CWRR, tid_q, LEN_WRR, 15'h0, I_CFG_ERR, 96'h0}; // RULE_14 RULE_15
				hcnt_q <= WRR_HDR;
				dcnt_q <= 9'h000;
			end
			else if (to_tx)
			begin
				hdr_q <= {SIG, (st_q == ST_AUTO) ? OP_UPL : OP_SRX, utid_q, ts_q, I_MAC_ADDR, 7'h00, wcnt_d}; // RULE_05 RULE_18
				hcnt_q <= UPL_HDR;
				dcnt_q <= wcnt_d;
				utid_q <= utid_q + 16'h0001;
			end
			else if (tx_fire && !tx_dat)
			begin
				hdr_q <= {hdr_q[183:0], 8'h00}; // RULE_01
				hcnt_q <= hcnt_q - 5'h01;
			end
			else if (tx_fire)
				dcnt_q <= dcnt_q - 9'h001;
			didx_q <= to_tx ? 8'h00 : buf_bus.raddr;
		end
	end

	////////////////////////////////////////////////////////////////
	// Timestamp and SPI master
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RESET_N)
		begin
			tick_q <= 10'h000;
			ts_q <= 64'h0;
			miso_m_q <= 1'b0;
			miso_s_q <= 1'b0;
		end
		else
		begin
			tick_q <= (tick_q == TICK_LAST) ? 10'h000 : tick_q + 10'h001;
			if (tick_q == TICK_LAST) ts_q <= ts_q + 64'h1;
			miso_m_q <= I_SPI_MISO;
			miso_s_q <= miso_m_q;
		end
	end

	// Mode 0: data changes on the falling edge, sampled on the rising edge
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RESET_N)
		begin
			spi_busy_q <= 1'b0;
			spi_done_q <= 1'b0;
			sclk_q <= 1'b0;
			div_q <= 3'h0;
			half_q <= 4'h0;
			spi_sh_q <= 8'h00;
			spi_rx_q <= 8'h00;
			pidx_q <= 3'h0;
		end
		else
		begin
			spi_done_q <= 1'b0;
			if (st_q == ST_IDLE) pidx_q <= 3'h0;
			else if (auto_go) pidx_q <= pidx_q + 3'h1;
			if (spi_start)
			begin
				spi_busy_q <= 1'b1; // RULE_08
				spi_sh_q <= spi_byte;
				div_q <= 3'h0;
				half_q <= 4'h0;
				sclk_q <= 1'b0;
			end
			else if (spi_busy_q)
			begin
				div_q <= spi_tick ? 3'h0 : div_q + 3'h1;
				if (spi_tick)
				begin
					sclk_q <= !sclk_q;
					half_q <= half_q + 4'h1;
					if (!sclk_q) spi_rx_q <= {spi_rx_q[6:0], miso_s_q};
					else spi_sh_q <= {spi_sh_q[6:0], 1'b0};
					if (half_q == 4'hF) spi_busy_q <= 1'b0;
					if (half_q == 4'hF) spi_done_q <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	sig_first_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // RULE_01
		$rose(O_TX_VALID) |-> O_TX_DATA == SIG[31:24] && hcnt_q != 5'h00) else $error("reply lacks signature");
	ser_fwd_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // RULE_03
		st_q == ST_SERW && rx_fire |=> O_SER_VALID && O_SER_DATA == $past(I_RX_DATA)) else $error("serial byte lost");
	ser_zero_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // RULE_04
		decide && sig_ok && op_w == OP_SERW && len_w == 16'h0000 |=> st_q != ST_SERW [*2])
		else $error("zero length emitted data");
	upl_op_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // RULE_05
		st_q == ST_AUTO && to_tx |=> hdr_q[159:144] == OP_UPL && dcnt_q == 9'(POLL_BYTES)) else $error("bad upload");
	spi_idle_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // RULE_06
		O_SPI_CS_N |-> !O_SPI_SCLK) else $error("clock while deselected");
	auto_cmd_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // RULE_07
		auto_go |=> spi_busy_q && spi_sh_q == $past(spi_byte) ##1 !O_SPI_CS_N) else $error("poll byte not sent");
	spi_dl_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // RULE_08
		st_q == ST_SPIDL && rx_fire |=> spi_busy_q [*8]) else $error("download byte not shifted");
	rd_reply_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // RULE_10 RULE_11 RULE_12
		st_q == ST_CFG && I_CFG_ACK && !wr_q |=> hdr_q[159:144] == OP_CRDR && hdr_q[127:112] == LEN_RDR
		&& hdr_q[79:72] == $past(I_CFG_RDATA[7:0])) else $error("bad read reply");
	wr_reply_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // RULE_14 RULE_15
		st_q == ST_CFG && I_CFG_ACK && wr_q |=> hdr_q[159:144] == OP_CWRR
		&& hdr_q[96] == $past(I_CFG_ERR) && hcnt_q == WRR_HDR) else $error("bad write reply");
	awake_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // RULE_16
		decide && is_cfg && !I_AWAKE |=> st_q != ST_CFGF) else $error("config while asleep");
	srx_up_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // RULE_18
		st_q == ST_SRX && to_tx |=> hdr_q[159:144] == OP_SRX) else $error("bad serial upload");
	drop_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) // RULE_19
		decide && !sig_ok |=> (st_q == ST_IDLE || st_q == ST_DRAIN) && !O_TX_VALID) else $error("bad datagram acted on");
endmodule // idg_engine
`default_nettype wire

//--- idg_pkg.sv
// Constants, encodings and state type for the datagram command engine
`default_nettype none
package idg_pkg;
	// Arbitrary protocol signature value
	localparam logic [31:0] SIG = 32'h0A5C3E71;
	localparam logic [15:0] OP_SRX = 16'h0005;
	localparam logic [15:0] OP_SERW = 16'h0006;
	localparam logic [15:0] OP_UPL = 16'h0007;
	localparam logic [15:0] OP_SPIW = 16'h0008;
	localparam logic [15:0] OP_CRD = 16'h0010;
	localparam logic [15:0] OP_CRDR = 16'h0011;
	localparam logic [15:0] OP_CWR = 16'h0012;
	localparam logic [15:0] OP_CWRR = 16'h0013;
	localparam logic [15:0] LEN_RDR = 16'h0008;
	localparam logic [15:0] LEN_WRR = 16'h0002;
	localparam logic [15:0] MAX_LEN = 16'h0100;
	localparam logic [8:0] MAX_LAST = 9'h0FF;
	localparam logic [4:0] HDR_LAST = 5'h09;
	localparam logic [4:0] CRD_LAST = 5'h0D;
	localparam logic [4:0] CWR_LAST = 5'h11;
	localparam logic [4:0] UPL_HDR = 5'h18;
	localparam logic [4:0] RDR_HDR = 5'h12;
	localparam logic [4:0] WRR_HDR = 5'h0C;
	localparam logic [2:0] POLL_BYTES = 3'h4;
	localparam int BUF_AW = 8;
	localparam int BUF_DEPTH = 256;
	localparam real CLK_NS = 8.0;
	localparam real TICK_US = 7.62939;
	localparam int TICK_CYC = $rtoi(TICK_US * 1000.0 / CLK_NS);
	localparam logic [9:0] TICK_LAST = 10'(TICK_CYC - 1);
	localparam real SPI_HALF_NS = 40.0;
	localparam int SPI_HALF_CYC = $rtoi(SPI_HALF_NS / CLK_NS);
	localparam logic [2:0] SPI_DIV_LAST = 3'(SPI_HALF_CYC - 1);

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0, ST_RXH = 4'h1, ST_CFGF = 4'h3, ST_CFG = 4'h2,
		ST_TX = 4'h6, ST_DRAIN = 4'h7, ST_SERW = 4'h5, ST_SPIDL = 4'h4,
		ST_AUTO = 4'hC, ST_SRX = 4'hD
	} idg_state_t;

	function automatic logic [31:0] idg_swap32(input logic [31:0] w);
		idg_swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction
endpackage
`default_nettype wire

//--- idg_buf_if.sv
// Write and read port bundle of the payload buffer
`default_nettype none
interface idg_buf_if;
	import idg_pkg::*;
	logic we;
	logic [BUF_AW-1:0] waddr;
	logic [7:0] wdata;
	logic [BUF_AW-1:0] raddr;
	logic [7:0] rdata;
	modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

//--- idg_buf_mem.sv
// Payload buffer, one write and one registered read port
`default_nettype none
module idg_buf_mem
	import idg_pkg::*;
(
	input wire logic i_clk,
	idg_buf_if.mem bus
);
	logic [7:0] ram_q [0:BUF_DEPTH-1];

	always_ff @(posedge i_clk)
	begin
		if (bus.we)
		begin
			ram_q[bus.waddr] <= bus.wdata;
		end
		bus.rdata <= ram_q[bus.raddr];
	end
endmodule // idg_buf_mem
`default_nettype wire

//--- idg_far_model.sv
// Host-side partner: reply sink with random stalls and a mode 0 SPI slave
`default_nettype none
module idg_far_model
(
	input wire logic i_clk,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	output logic o_tx_ready,
	input wire logic i_sclk,
	input wire logic i_mosi,
	input wire logic i_cs_n,
	output logic o_miso
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$];
	logic [7:0] mosi_q[$];
	logic [15:0] lfsr_q = 16'hACE1;
	logic [7:0] sh_in = 8'h00;
	logic [7:0] sh_out = 8'h00;
	int nbit = 0;
	int nbyte = 0;
	initial o_tx_ready = 1'b0;
	initial o_miso = 1'b0;
	////////////////////////////////////////////////////////////////
	// Stalls about a quarter of the cycles, so every reply byte must be held
	always @(negedge i_clk)
	begin
		lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		o_tx_ready <= lfsr_q[0] | lfsr_q[1];
	end
	always @(posedge i_clk)
	begin
		if (i_tx_valid && o_tx_ready)
			got.push_back(i_tx_data);
	end
	////////////////////////////////////////////////////////////////
	// Slave sends 5A, 5B, ... in each frame; first bit stands when select falls
	always @(negedge i_cs_n)
	begin
		nbit = 0;
		nbyte = 0;
		sh_out = 8'h5A;
		o_miso = sh_out[7];
	end
	always @(posedge i_sclk)
	begin
		if (!i_cs_n)
		begin
			sh_in = {sh_in[6:0], i_mosi};
			nbit = nbit + 1;
			if (nbit == 8)
			begin
				mosi_q.push_back(sh_in);
				nbit = 0;
				nbyte = nbyte + 1;
			end
		end
	end
	always @(negedge i_sclk)
	begin
		if (!i_cs_n)
		begin
			sh_out = (nbit == 0) ? 8'(8'h5A + nbyte) : {sh_out[6:0], 1'b0};
			o_miso = sh_out[7];
		end
	end
	// Released line shows the inverse, never a stale bit
	always @(posedge i_cs_n)
		o_miso = ~o_miso;
endmodule // idg_far_model
`default_nettype wire

//--- test_io_config_datagram_engine.sv
// Self-checking bench for the datagram command engine
`default_nettype none
module test_io_config_datagram_engine
	import idg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, ser_valid, ser_ready;
	logic srx_valid, srx_last, srx_ready, sclk, mosi, cs_n, miso, auto_evt, awake;
	logic cfg_req, cfg_wr, cfg_ack, cfg_err, seen_wr;
	logic [1:0] rx_path, tx_path;
	logic [7:0] rx_data, tx_data, ser_data, srx_data;
	logic [15:0] cfg_bank, cfg_loc, seen_bank, seen_loc, bk, lc, tid;
	logic [31:0] poll_cmd, cfg_wdata, cfg_rdata, seen_wdata, val, r;
	logic [47:0] mac;
	logic [7:0] q[$], e[$], ser_q[$];
	logic [2:0] lp_q[$];
	integer seed = 32'hBFD7;
	int miscompares = 0, check_count = 0, cyc = 0, req_cnt = 0, cw = 0, cfg_delay = 1, k, n;
	int lens[4] = '{0, 1, 256, 5};
	always #4 clk = ~clk;
	idg_engine idg_engine_i (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_RX_DATA(rx_data), .I_RX_VALID(rx_valid),
		.I_RX_LAST(rx_last), .I_RX_PATH(rx_path), .O_RX_READY(rx_ready), .O_TX_DATA(tx_data),
		.O_TX_VALID(tx_valid), .O_TX_LAST(tx_last), .O_TX_PATH(tx_path), .I_TX_READY(tx_ready),
		.O_SER_DATA(ser_data), .O_SER_VALID(ser_valid), .I_SER_READY(ser_ready), .I_SRX_DATA(srx_data),
		.I_SRX_VALID(srx_valid), .I_SRX_LAST(srx_last), .O_SRX_READY(srx_ready), .O_SPI_SCLK(sclk),
		.O_SPI_MOSI(mosi), .O_SPI_CS_N(cs_n), .I_SPI_MISO(miso), .I_AUTO_EVT(auto_evt), .I_POLL_CMD(poll_cmd),
		.I_MAC_ADDR(mac), .I_AWAKE(awake), .O_CFG_REQ(cfg_req), .O_CFG_WR(cfg_wr), .O_CFG_BANK(cfg_bank),
		.O_CFG_LOC(cfg_loc), .O_CFG_WDATA(cfg_wdata), .I_CFG_ACK(cfg_ack), .I_CFG_RDATA(cfg_rdata),
		.I_CFG_ERR(cfg_err));
	idg_far_model idg_far_model_i (.i_clk(clk), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
		.o_tx_ready(tx_ready), .i_sclk(sclk), .i_mosi(mosi), .i_cs_n(cs_n), .o_miso(miso));
	////////////////////////////////////////////////////////////////
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic put(ref logic [7:0] d[$], input logic [63:0] v, input int nb);
		for (int i = nb - 1; i >= 0; i--)
			d.push_back(v[i*8+:8]);
	endtask
	task automatic head(ref logic [7:0] d[$], input logic [15:0] op, input logic [15:0] t, input logic [15:0] len);
		d = {};
		put(d, {SIG, op}, 6);
		put(d, {t, len}, 4);
	endtask
	// Holds each byte from a falling edge until ready is seen before a rising one
	task send(input logic [1:0] p, input bit srx);
		foreach (q[i])
		begin
			@(negedge clk);
			{rx_data, srx_data} = {q[i], q[i]};
			{rx_valid, srx_valid} = {!srx, srx};
			{rx_last, srx_last} = {2{i == q.size() - 1}};
			rx_path = p;
			#1;
			n = 0;
			while (!(srx ? srx_ready : rx_ready) && n < 400)
			begin
				@(negedge clk);
				#1;
				n++;
			end
		end
		@(negedge clk);
		{rx_valid, srx_valid, rx_last, srx_last} = 4'h0;
	endtask
	// Timestamp bytes are skipped for uploads: only the engine's tick counter knows them
	task got_check(input bit upl, input logic [1:0] pth);
		k = 0;
		while (idg_far_model_i.got.size() < e.size() && k < 6000)
		begin
			@(negedge clk);
			k++;
		end
		chk("reply size", idg_far_model_i.got.size(), e.size());
		foreach (e[i])
			if (!(upl && i >= 8 && i < 16) && i < idg_far_model_i.got.size())
				chk("reply byte", idg_far_model_i.got[i], e[i]);
		// Only the final byte may carry last, and the reply returns on the request's path
		foreach (lp_q[i])
			chk("reply end and path", lp_q[i], {1'(i == e.size() - 1), pth});
		idg_far_model_i.got = {};
		lp_q = {};
	endtask
	////////////////////////////////////////////////////////////////
	// Register bank stand-in: acks after a chosen wait and records the access
	always @(negedge clk)
	begin
		cfg_ack <= 1'b0;
		r = $random(seed);
		ser_ready <= r[0] | r[1];
		if (cfg_req && !cfg_ack)
		begin
			cw = cw + 1;
			if (cw >= cfg_delay)
			begin
				cfg_ack <= 1'b1;
				cw = 0;
				req_cnt++;
				{seen_wr, seen_bank, seen_loc, seen_wdata} = {cfg_wr, cfg_bank, cfg_loc, cfg_wdata};
			end
		end
	end
	always @(posedge clk)
	begin
		if (ser_valid && ser_ready)
			ser_q.push_back(ser_data);
		if (tx_valid && tx_ready)
			lp_q.push_back({tx_last, tx_path});
		cyc++;
		if (cyc == 40000)
		begin
			miscompares++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		{rst_n, rx_valid, rx_last, srx_valid, srx_last, auto_evt, cfg_err} = 7'h00;
		{rx_path, rx_data, srx_data, cfg_rdata} = 50'h0;
		awake = 1'b1;
		poll_cmd = $random(seed);
		mac = {16'($random(seed)), 32'($random(seed))};
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		for (int p = 0; p < 3; p++)
			for (int w = 0; w < 2; w++)
			begin
				{bk, lc, val, tid} = 80'({$random(seed), $random(seed), $random(seed)});
				{cfg_rdata, cfg_err, cfg_delay} = {val, p[0] ^ w[0], 1 + p * 3};
				head(q, w ? OP_CWR : OP_CRD, tid, w ? 16'h0008 : 16'h0004);
				put(q, {bk, lc}, 4);
				if (w)
					put(q, {val[7:0], val[15:8], val[23:16], val[31:24]}, 4);
				send(2'(p), 0);
				head(e, w ? OP_CWRR : OP_CRDR, tid, w ? LEN_WRR : LEN_RDR);
				if (w)
					put(e, {15'h0000, cfg_err}, 2);
				else
					put(e, {bk, lc, val[7:0], val[15:8], val[23:16], val[31:24]}, 8);
				got_check(0, 2'(p));
				chk("access count", req_cnt, p * 2 + w + 1);
				chk("access kind", seen_wr, w);
				chk("access address", {seen_bank, seen_loc}, {bk, lc});
				if (w)
					chk("write value", seen_wdata, val);
			end
		awake = 1'b0;
		send(2'h0, 0);
		q[0] = q[0] ^ 8'h01;
		awake = 1'b1;
		send(2'h0, 0);
		head(q, 16'h0009, 16'h0001, 16'h0000);
		send(2'h1, 0);
		repeat (40) @(negedge clk);
		chk("dropped access", req_cnt, 6);
		chk("dropped reply", idg_far_model_i.got.size(), 0);
		foreach (lens[j])
		begin
			head(q, OP_SERW, 16'(j), 16'(lens[j]));
			for (int i = 0; i < lens[j]; i++)
				q.push_back(8'($random(seed)));
			e = q[10:$];
			ser_q = {};
			send(2'h1, 0);
			k = 0;
			while (ser_q.size() < lens[j] && k < 2000)
			begin
				@(negedge clk);
				k++;
			end
			repeat (20) @(negedge clk);
			chk("serial count", ser_q.size(), lens[j]);
			foreach (e[i])
				chk("serial byte", ser_q[i], e[i]);
		end
		head(q, OP_SPIW, 16'h0033, 16'h0002);
		put(q, 16'($random(seed)), 2);
		e = q[10:$];
		idg_far_model_i.mosi_q = {};
		send(2'h2, 0);
		repeat (200) @(negedge clk);
		chk("spi out count", idg_far_model_i.mosi_q.size(), 2);
		foreach (e[i])
			chk("spi out byte", idg_far_model_i.mosi_q[i], e[i]);
		idg_far_model_i.mosi_q = {};
		auto_evt = 1'b1;
		@(negedge clk);
		auto_evt = 1'b0;
		head(e, OP_UPL, 16'h0000, 16'h0000);
		e = e[0:7];
		put(e, 64'h0, 8);
		put(e, {mac, 16'h0004}, 8);
		put(e, 32'h5A5B5C5D, 4);
		got_check(1, 2'h0);
		foreach (idg_far_model_i.mosi_q[i])
			chk("poll byte", idg_far_model_i.mosi_q[i], poll_cmd[31-8*i-:8]);
		chk("poll count", idg_far_model_i.mosi_q.size(), 4);
		q = {8'h31, 8'h32, 8'h33};
		send(2'h0, 1);
		head(e, OP_SRX, 16'h0001, 16'h0000);
		e = e[0:7];
		put(e, 64'h0, 8);
		put(e, {mac, 16'h0003}, 8);
		e = {e, q};
		got_check(1, 2'h0);
		complete_run();
	end
endmodule // test_io_config_datagram_engine
`default_nettype wire
